// File: logic/ldm_pkg.sv
package ldm_pkg;
  // ==========================================
  // bus identity and register map
  localparam logic [6:0] DEV_ADDR    = 7'h2c;
  localparam int         NREG        = 6;
  localparam logic [7:0] A_DIM_METH  = 8'ha0;
  localparam logic [7:0] A_FULL_SCL  = 8'ha1;
  localparam logic [7:0] A_UV_LEVEL  = 8'ha2;
  localparam logic [7:0] A_SW_RATE   = 8'ha3;
  localparam logic [7:0] A_EDGE_SLP  = 8'ha4;
  localparam logic [7:0] A_OC_SHDN   = 8'ha5;
  localparam logic [7:0] A_STORE_CTL = 8'hff;
  localparam logic [7:0] REG_ADDR [NREG] = '{A_DIM_METH, A_FULL_SCL, A_UV_LEVEL,
                                             A_SW_RATE, A_EDGE_SLP, A_OC_SHDN};
  localparam logic [7:0] REG_RST  [NREG] = '{8'h01, 8'h05, 8'h03, 8'h01, 8'h00, 8'h00};
  localparam logic [7:0] REG_MASK [NREG] = '{8'h03, 8'h0f, 8'h07, 8'h03, 8'h03, 8'h01};
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [7:0] CTL_MASK = 8'h81;
  localparam int         CTL_STORE_BIT = 7;
  localparam int         CTL_NVRD_BIT  = 0;
  localparam logic [2:0] UV_MAX   = 3'h4;
  // ==========================================
  // brightness levels, 1023 = full scale
  localparam logic [9:0] LVL_FULL    = 10'h3ff;
  localparam logic [9:0] LVL_QUARTER = 10'h100;
  localparam logic [9:0] LVL_MIN     = 10'h00a;
  // ==========================================
  // timing
  localparam int CLK_MHZ        = 200;
  localparam int MIN_DECODE_US  = 400;
  localparam int MIN_DECODE_CYC = MIN_DECODE_US * CLK_MHZ;
  localparam int FULL_TMO_MS    = 20;
  localparam int FULL_TMO_CYC   = FULL_TMO_MS * 1000 * CLK_MHZ;
  localparam int CNT_W          = 23;
  // ==========================================
  // types
  typedef enum logic [1:0] {
    M_DIRECT = 2'h0, M_MIXED = 2'h1, M_ANALOG = 2'h2, M_RSVD = 2'h3
  } ldm_mode_e;
  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_DEV = 3'b001, I_PTR = 3'b011, I_WR = 3'b010, I_RD = 3'b110
  } ldm_i2c_e;
  typedef struct packed {
    ldm_mode_e  mode;
    logic [3:0] full_scale;
    logic [2:0] undervoltage_threshold;
    logic [1:0] switching_rate_select;
    logic [1:0] slew_rate_select;
    logic       current_limit_shutdown_enable;
  } ldm_cfg_s;
  typedef struct packed {
    logic [5:0] on;
    logic [9:0] level;
  } ldm_sink_s;
endpackage

// File: logic/ldm_top.sv
`timescale 1ns/1ps
// Functional notes
// - mixed mode: input duty becomes one 10-bit brightness for all six sinks
// - mixed mode, duty 25..100%: steady amplitude 25..100% of full scale
// - mixed mode, duty under 25%: sinks pulse at input rate, 25% amplitude
// - analog mode: never pulsed, amplitude follows duty over 1..100%
// - analog brightness resolution at most 10 bits
// - direct mode: sinks on while input high, off while low
// - method field 1:0: 00 direct, 01 mixed, 10 analog, reset 01
// - method register at A0h, default 01h
// - reserved bits drop writes and read as zero
// - four-bit full-scale code at A1h bits 3:0, reset 5
// - undervoltage code bits 2:0, codes above 100 act as 100, reset 3
// - switching code bits 1:0 selects 450/600/800/1200 kHz, reset 1
// - undervoltage at A2h default 03h, switching at A3h default 01h
// - slew-rate selection at A4h, default 00h
// - current-limit shutdown enable at A5h, default 00h disabled
// - control at FFh, default 00h, steers access to working or stored set
// - every configuration register is readable and writable
// - decoded modes wait two periods and 400 us; direct acts at once
// - input held high after first rise: full duty after about 20 ms
// - I2C address byte 58h, then register pointer, auto-increment
// - control bit 0 low reads working set, high reads stored set
module ldm_top #(
  parameter int MIN_DECODE_CYC = ldm_pkg::MIN_DECODE_CYC,
  parameter int FULL_TMO_CYC   = ldm_pkg::FULL_TMO_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        brightness_pwm_input,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output ldm_pkg::ldm_cfg_s  cfg,
  output ldm_pkg::ldm_sink_s sink,
  output logic             nv_store_trigger
);
  localparam int CW = ldm_pkg::CNT_W;
  localparam logic [CW-1:0] TMO_LAST = CW'(FULL_TMO_CYC - 1);
  localparam logic [CW-1:0] SET_LAST = CW'(MIN_DECODE_CYC - 1);

  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    reg_idx = 3'h7;
    for (int i = 0; i < ldm_pkg::NREG; i++) begin
      if (a == ldm_pkg::REG_ADDR[i]) reg_idx = 3'(i);
    end
  endfunction

  // ==========================================
  // pin synchronisers, change taken once stages 2 and 3 agree
  logic [2:0] pwm_s, scl_s, sda_s;
  logic       pwm_f, scl_f, sda_f, scl_p, sda_p, pwm_p;
  always_ff @(posedge clk) begin
    pwm_s <= {pwm_s[1:0], brightness_pwm_input};
    scl_s <= {scl_s[1:0], scl_i};
    sda_s <= {sda_s[1:0], sda_i};
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_f <= 1'b0;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      pwm_p <= 1'b0;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      if (pwm_s[1] == pwm_s[2]) pwm_f <= pwm_s[2];
      if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
      pwm_p <= pwm_f;
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end
  wire scl_rise = scl_f & ~scl_p;
  wire scl_fall = ~scl_f & scl_p;
  wire i_start  = scl_f & scl_p & sda_p & ~sda_f;
  wire i_stop   = scl_f & scl_p & ~sda_p & sda_f;
  wire pwm_rise = pwm_f & ~pwm_p;

  // ==========================================
  // configuration registers, working and stored copies
  logic [7:0] wk_r [ldm_pkg::NREG];
  logic [7:0] nv_r [ldm_pkg::NREG];
  logic [7:0] ctl_r, ptr_r, sh_r, tx_r;
  logic       wr_en;
  wire  [2:0] ptr_idx = reg_idx(ptr_r);
  wire        nv_sel  = ctl_r[ldm_pkg::CTL_NVRD_BIT];
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_r == ldm_pkg::A_STORE_CTL) rd_byte = ctl_r;
    else if (ptr_idx != 3'h7) rd_byte = nv_sel ? nv_r[ptr_idx] : wk_r[ptr_idx];
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < ldm_pkg::NREG; i++) begin
        wk_r[i] <= ldm_pkg::REG_RST[i];
        nv_r[i] <= ldm_pkg::REG_RST[i];
      end
    end else begin
      if (ctl_r[ldm_pkg::CTL_STORE_BIT]) begin
        for (int i = 0; i < ldm_pkg::NREG; i++) nv_r[i] <= wk_r[i];
      end
      if (wr_en && ptr_idx != 3'h7) begin
        if (nv_sel) nv_r[ptr_idx] <= sh_r & ldm_pkg::REG_MASK[ptr_idx];
        else wk_r[ptr_idx] <= sh_r & ldm_pkg::REG_MASK[ptr_idx];
      end
    end
  end
  // store request clears itself once the copy has been taken
  always_ff @(posedge clk) begin
    if (srst) ctl_r <= ldm_pkg::CTL_RST;
    else if (wr_en && ptr_r == ldm_pkg::A_STORE_CTL) ctl_r <= sh_r & ldm_pkg::CTL_MASK;
    else ctl_r[ldm_pkg::CTL_STORE_BIT] <= 1'b0;
  end
  always_ff @(posedge clk) begin
    if (srst) nv_store_trigger <= 1'b0;
    else nv_store_trigger <= ctl_r[ldm_pkg::CTL_STORE_BIT];
  end
  always_comb begin
    cfg.mode = ldm_pkg::ldm_mode_e'(wk_r[0][1:0]);
    cfg.full_scale = wk_r[1][3:0];
    cfg.undervoltage_threshold = (wk_r[2][2:0] > ldm_pkg::UV_MAX) ?
                                 ldm_pkg::UV_MAX : wk_r[2][2:0];
    cfg.switching_rate_select = wk_r[3][1:0];
    cfg.slew_rate_select = wk_r[4][1:0];
    cfg.current_limit_shutdown_enable = wk_r[5][0];
  end

  // ==========================================
  // I2C slave
  ldm_pkg::ldm_i2c_e st_r;
  logic [3:0] bit_r;
  logic       rd_ok_r, oe_r;
  assign scl_o  = 1'b0;
  assign scl_oe = 1'b0;
  assign sda_o  = 1'b0;
  assign sda_oe = oe_r;
  assign wr_en  = scl_fall && bit_r == 4'h8 && st_r == ldm_pkg::I_WR;
  always_ff @(posedge clk) begin
    if (srst || i_stop) begin
      st_r <= ldm_pkg::I_IDLE;
      bit_r <= 4'h0;
      oe_r <= 1'b0;
      rd_ok_r <= 1'b0;
    end else if (i_start) begin
      st_r <= ldm_pkg::I_DEV;
      bit_r <= 4'h0;
      oe_r <= 1'b0;
      rd_ok_r <= 1'b0;
    end else if (st_r != ldm_pkg::I_IDLE) begin
      if (scl_rise) begin
        bit_r <= bit_r + 4'h1;
        if (bit_r < 4'h8) sh_r <= {sh_r[6:0], sda_f};
        else if (st_r == ldm_pkg::I_RD) rd_ok_r <= ~sda_f;
      end
      if (scl_fall) begin
        unique case (bit_r)
          4'h8: begin
            oe_r <= 1'b1;
            unique case (st_r)
              ldm_pkg::I_DEV: begin
                if (sh_r[7:1] == ldm_pkg::DEV_ADDR) begin
                  st_r <= sh_r[0] ? ldm_pkg::I_RD : ldm_pkg::I_PTR;
                  rd_ok_r <= sh_r[0];
                end else begin
                  st_r <= ldm_pkg::I_IDLE;
                  oe_r <= 1'b0;
                end
              end
              ldm_pkg::I_PTR: begin
                ptr_r <= sh_r;
                st_r <= ldm_pkg::I_WR;
              end
              ldm_pkg::I_WR: ptr_r <= ptr_r + 8'h01;
              default: oe_r <= 1'b0;
            endcase
          end
          4'h9: begin
            bit_r <= 4'h0;
            oe_r <= 1'b0;
            if (st_r == ldm_pkg::I_RD) begin
              if (rd_ok_r) begin
                tx_r <= rd_byte;
                oe_r <= ~rd_byte[7];
                ptr_r <= ptr_r + 8'h01;
              end else st_r <= ldm_pkg::I_IDLE;
            end
          end
          default: oe_r <= (st_r == ldm_pkg::I_RD) && ~tx_r[3'(4'h7 - bit_r)];
        endcase
      end
    end
  end

  // ==========================================
  // duty measurement
  logic [CW-1:0] per_r, hi_r, hi_last_r, set_r, dper_r;
  logic [CW:0]   rem_r;
  logic [10:0]   q_r;
  logic [3:0]    div_r;
  logic [1:0]    npr_r;
  logic          seen_r, tmo_r, upd_r;
  logic [9:0]    duty_r;
  wire settled = (set_r == SET_LAST) && (npr_r == 2'h2);
  always_ff @(posedge clk) begin
    if (srst) set_r <= '0;
    else if (set_r != SET_LAST) set_r <= set_r + 1'b1;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      per_r <= '0;
      hi_r <= '0;
      hi_last_r <= '0;
      seen_r <= 1'b0;
      npr_r <= 2'h0;
      tmo_r <= 1'b0;
    end else if (pwm_rise) begin
      // the rise cycle is the first counted cycle of the new period
      per_r <= CW'(1);
      hi_r <= CW'(1);
      hi_last_r <= hi_r;
      seen_r <= 1'b1;
      tmo_r <= 1'b0;
      if (seen_r && npr_r != 2'h2) npr_r <= npr_r + 2'h1;
    end else begin
      if (per_r != TMO_LAST) per_r <= per_r + 1'b1;
      if (pwm_f && hi_r != TMO_LAST) hi_r <= hi_r + 1'b1;
      if (seen_r && pwm_f && per_r == TMO_LAST && hi_r == TMO_LAST) tmo_r <= 1'b1;
    end
  end
  // restoring divider: q = hi * 1024 / period, one bit a cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      div_r <= 4'h0;
      upd_r <= 1'b0;
      q_r <= '0;
      rem_r <= '0;
      dper_r <= '0;
    end else begin
      upd_r <= 1'b0;
      if (pwm_rise && seen_r) begin
        div_r <= 4'hb;
        rem_r <= {1'b0, hi_r};
        dper_r <= per_r;
        q_r <= '0;
      end else if (div_r != 4'h0) begin
        div_r <= div_r - 4'h1;
        upd_r <= (div_r == 4'h1);
        if (rem_r >= {1'b0, dper_r}) begin
          q_r <= {q_r[9:0], 1'b1};
          rem_r <= (rem_r - {1'b0, dper_r}) << 1;
        end else begin
          q_r <= {q_r[9:0], 1'b0};
          rem_r <= rem_r << 1;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) duty_r <= ldm_pkg::LVL_FULL;
    else if (settled && tmo_r) duty_r <= ldm_pkg::LVL_FULL;
    else if (settled && upd_r) duty_r <= q_r[10] ? ldm_pkg::LVL_FULL : q_r[9:0];
  end

  // ==========================================
  // sink drive
  wire [CW+1:0] on_len = {hi_last_r, 2'b00};
  wire          gate   = ({2'b00, per_r} <= on_len) || tmo_r;
  ldm_pkg::ldm_sink_s sk_nxt;
  always_comb begin
    sk_nxt.on = 6'h00;
    sk_nxt.level = ldm_pkg::LVL_FULL;
    unique case (cfg.mode)
      ldm_pkg::M_DIRECT: sk_nxt.on = {6{pwm_f}};
      ldm_pkg::M_MIXED: begin
        if (duty_r >= ldm_pkg::LVL_QUARTER) begin
          sk_nxt.on = {6{settled}};
          sk_nxt.level = duty_r;
        end else begin
          sk_nxt.on = {6{settled & gate}};
          sk_nxt.level = ldm_pkg::LVL_QUARTER;
        end
      end
      ldm_pkg::M_ANALOG: begin
        sk_nxt.on = {6{settled}};
        sk_nxt.level = (duty_r < ldm_pkg::LVL_MIN) ? ldm_pkg::LVL_MIN : duty_r;
      end
      ldm_pkg::M_RSVD: sk_nxt.on = 6'h00;
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) sink <= '0;
    else sink <= sk_nxt;
  end

  // ==========================================
  // checks
  AST_MODE_RST: assert property (@(posedge clk) srst |=> cfg.mode == ldm_pkg::M_MIXED)
    else $error("method not 01 after reset");
  AST_DIRECT: assert property (@(posedge clk) disable iff (srst)
    cfg.mode == ldm_pkg::M_DIRECT && $stable(cfg.mode) |=> sink.on == {6{$past(pwm_f)}})
    else $error("direct mode sinks not following input");
  AST_ANALOG: assert property (@(posedge clk) disable iff (srst)
    cfg.mode == ldm_pkg::M_ANALOG && settled ##1 cfg.mode == ldm_pkg::M_ANALOG
    |-> sink.on == 6'h3f && sink.level >= ldm_pkg::LVL_MIN)
    else $error("analog mode pulsed or below floor");
  AST_MIX_LOW: assert property (@(posedge clk) disable iff (srst)
    cfg.mode == ldm_pkg::M_MIXED && duty_r < ldm_pkg::LVL_QUARTER
    |=> sink.level == ldm_pkg::LVL_QUARTER)
    else $error("mixed low duty not at quarter level");
  AST_RSVD_OFF: assert property (@(posedge clk) disable iff (srst)
    cfg.mode == ldm_pkg::M_RSVD |=> sink.on == 6'h00)
    else $error("reserved method drives sinks");
  AST_MASK: assert property (@(posedge clk) disable iff (srst)
    (wk_r[1] & ~ldm_pkg::REG_MASK[1]) == 8'h00 && (ctl_r & ~ldm_pkg::CTL_MASK) == 8'h00)
    else $error("reserved bits stored");
  AST_UV: assert property (@(posedge clk) disable iff (srst)
    cfg.undervoltage_threshold <= ldm_pkg::UV_MAX)
    else $error("undervoltage code above 100");
  AST_SETTLE: assert property (@(posedge clk) disable iff (srst)
    $changed(duty_r) |-> $past(settled))
    else $error("brightness changed before settling");
  AST_STORE: assert property (@(posedge clk) disable iff (srst)
    ctl_r[ldm_pkg::CTL_STORE_BIT] |=> nv_store_trigger && nv_r[0] == $past(wk_r[0]))
    else $error("store request not copied");
  AST_ACK: assert property (@(posedge clk) disable iff (srst || i_stop || i_start)
    scl_fall && bit_r == 4'h8 && st_r == ldm_pkg::I_DEV && sh_r[7:1] == ldm_pkg::DEV_ADDR
    |=> sda_oe)
    else $error("address not acknowledged");
endmodule

// File: sim/ldm_host.sv
`timescale 1ns/1ps
// ==========================================
// i2c bus master and brightness source
module ldm_host (
  input  wire logic clk,
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  output wire logic scl,
  output wire logic sda,
  output logic      pwm
);
  logic scl_m;
  logic sda_m;

  // open-drain lines with pull-ups
  assign scl = scl_m & ~scl_oe;
  assign sda = sda_m & ~sda_oe;

  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    pwm   = 1'b0;
  end

  task automatic q();
    repeat (8) @(negedge clk);
  endtask

  // data changes only while scl is low
  task automatic bit_io(input logic b, output logic s);
    sda_m = b;
    q();
    scl_m = 1'b1;
    q();
    s = sda;
    q();
    scl_m = 1'b0;
    q();
  endtask

  task automatic start();
    sda_m = 1'b1;
    q();
    scl_m = 1'b1;
    q();
    sda_m = 1'b0;
    q();
    scl_m = 1'b0;
    q();
  endtask

  task automatic stop();
    sda_m = 1'b0;
    q();
    scl_m = 1'b1;
    q();
    sda_m = 1'b1;
    q();
  endtask

  // msb first, ninth bit released unless acking a read
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(last, s);
    ack = ~s;
  endtask

  task automatic pwm_run(input int hi, input int per, input int n);
    repeat (n) begin
      pwm = 1'b1;
      repeat (hi) @(negedge clk);
      pwm = 1'b0;
      repeat (per - hi) @(negedge clk);
    end
  endtask
endmodule

// File: sim/ldm_top_tb_top.sv
`timescale 1ns/1ps
module ldm_top_tb_top;
  logic               clk;
  logic               srst;
  logic               scl_o;
  logic               scl_oe;
  logic               sda_o;
  logic               sda_oe;
  logic               nv_store_trigger;
  wire logic          scl;
  wire logic          sda;
  wire logic          pwm;
  ldm_pkg::ldm_cfg_s  cfg;
  ldm_pkg::ldm_sink_s sink;
  int                 miscompares;
  int                 check_count;
  int                 store_pulses;
  logic [7:0]         d;
  logic               ack;

  always #2.5 clk = ~clk;

  // one-cycle store pulses counted at the opposite edge
  always @(negedge clk) begin
    if (nv_store_trigger) store_pulses++;
  end

  ldm_top #(.MIN_DECODE_CYC(200), .FULL_TMO_CYC(2000)) dut (
    .clk(clk), .srst(srst), .brightness_pwm_input(pwm), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .cfg(cfg), .sink(sink),
    .nv_store_trigger(nv_store_trigger));

  ldm_host host (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda), .pwm(pwm));

  // ==========================================
  // checks and bus tasks
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got,
                     input int tol);
    check_count++;
    if ($isunknown(got) || (int'(got) > int'(exp) + tol) || (int'(got) + tol < int'(exp))) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [47:0] v, input int n);
    logic [7:0] rx;
    host.start();
    host.xfer(8'h58, 1'b1, rx, ack);
    chk("addr ack", 10'h001, 10'(ack), 0);
    host.xfer(a, 1'b1, rx, ack);
    for (int i = 0; i < n; i++) begin
      host.xfer(v[8*i +: 8], 1'b1, rx, ack);
    end
    host.stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    host.start();
    host.xfer(8'h58, 1'b1, v, ack);
    host.xfer(a, 1'b1, v, ack);
    host.start();
    host.xfer(8'h59, 1'b1, v, ack);
    host.xfer(8'hff, 1'b1, v, ack);
    host.stop();
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < ldm_pkg::NREG; i++) begin
      rd(ldm_pkg::REG_ADDR[i], d);
      chk("reset reg", 10'(ldm_pkg::REG_RST[i]), 10'(d), 0);
    end
    rd(ldm_pkg::A_STORE_CTL, d);
    chk("reset ctl", 10'(ldm_pkg::CTL_RST), 10'(d), 0);
    chk("uv reset", 10'(ldm_pkg::REG_RST[2]), 10'(cfg.undervoltage_threshold), 0);
    chk("scale reset", 10'(ldm_pkg::REG_RST[1]), 10'(cfg.full_scale), 0);
  endtask

  task automatic t_rw();
    logic [7:0] rx;
    wr(ldm_pkg::A_DIM_METH, 48'hffffffffffff, 6);
    for (int i = 0; i < ldm_pkg::NREG; i++) begin
      rd(ldm_pkg::REG_ADDR[i], d);
      chk("masked reg", 10'(ldm_pkg::REG_MASK[i]), 10'(d), 0);
    end
    chk("uv clamp", 10'(ldm_pkg::UV_MAX), 10'(cfg.undervoltage_threshold), 0);
    chk("rate sel", 10'h003, 10'(cfg.switching_rate_select), 0);
    chk("scale sel", 10'h00f, 10'(cfg.full_scale), 0);
    chk("slew sel", 10'h003, 10'(cfg.slew_rate_select), 0);
    chk("current_limit_shutdown_enable en", 10'h001, 10'(cfg.current_limit_shutdown_enable), 0);
    chk("pin drive", 10'h000, 10'({scl_o, scl_oe, sda_o}), 0);
    host.pwm_run(200, 400, 3);
    host.pwm = 1'b1;
    repeat (20) @(negedge clk);
    chk("rsvd on", 10'h000, 10'(sink.on), 0);
    host.pwm = 1'b0;
    rd(8'h10, d);
    chk("unmapped", 10'h000, 10'(d), 0);
    host.start();
    host.xfer(8'h5a, 1'b1, rx, ack);
    host.stop();
    chk("foreign ack", 10'h000, 10'(ack), 0);
    wr(ldm_pkg::A_DIM_METH, 48'h000001030501, 6);
  endtask

  task automatic t_ctl();
    wr(ldm_pkg::A_DIM_METH, 48'h02, 1);
    wr(ldm_pkg::A_STORE_CTL, 48'h01, 1);
    rd(ldm_pkg::A_DIM_METH, d);
    chk("stored read", 10'h001, 10'(d), 0);
    chk("working mode", 10'(ldm_pkg::M_ANALOG), 10'(cfg.mode), 0);
    wr(ldm_pkg::A_STORE_CTL, 48'h80, 1);
    chk("store pulse", 10'h001, 10'(store_pulses), 0);
    wr(ldm_pkg::A_STORE_CTL, 48'h01, 1);
    rd(ldm_pkg::A_DIM_METH, d);
    chk("stored copy", 10'h002, 10'(d), 0);
    wr(ldm_pkg::A_STORE_CTL, 48'h00, 1);
    rd(ldm_pkg::A_DIM_METH, d);
    chk("working read", 10'h002, 10'(d), 0);
  endtask

  task automatic t_direct();
    wr(ldm_pkg::A_DIM_METH, 48'h00, 1);
    host.pwm = 1'b1;
    repeat (8) @(negedge clk);
    chk("direct on", 10'h03f, 10'(sink.on), 0);
    host.pwm = 1'b0;
    repeat (8) @(negedge clk);
    chk("direct off", 10'h000, 10'(sink.on), 0);
  endtask

  task automatic t_mixed();
    wr(ldm_pkg::A_DIM_METH, 48'h01, 1);
    host.pwm_run(200, 400, 4);
    chk("mixed level", 10'h200, sink.level, 4);
    chk("mixed dc", 10'h03f, 10'(sink.on), 0);
    host.pwm_run(40, 400, 4);
    chk("mixed floor", ldm_pkg::LVL_QUARTER, sink.level, 0);
    host.pwm = 1'b1;
    repeat (100) @(negedge clk);
    chk("pulse on", 10'h03f, 10'(sink.on), 0);
    host.pwm = 1'b0;
    repeat (100) @(negedge clk);
    chk("pulse off", 10'h000, 10'(sink.on), 0);
  endtask

  task automatic t_analog();
    wr(ldm_pkg::A_DIM_METH, 48'h02, 1);
    host.pwm_run(20, 400, 4);
    chk("analog level", 10'h033, sink.level, 1);
    chk("analog dc", 10'h03f, 10'(sink.on), 0);
    host.pwm_run(5, 1000, 4);
    chk("analog floor", ldm_pkg::LVL_MIN, sink.level, 0);
    host.pwm = 1'b1;
    repeat (2500) @(negedge clk);
    chk("full duty", ldm_pkg::LVL_FULL, sink.level, 0);
    host.pwm = 1'b0;
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    clk  = 1'b0;
    srst = 1'b1;
    miscompares = 0;
    check_count = 0;
    store_pulses = 0;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (8) @(negedge clk);
    t_reset();
    t_rw();
    t_ctl();
    t_direct();
    t_mixed();
    t_analog();
    end_of_test();
  end
endmodule
